/* File: src/system_mode_controller.sv */
// Operating-mode controller: init, normal, stop, restart and supervision.
`timescale 1ns/1ps
`default_nettype none
module system_mode_controller
  import mode_ctrl_pkg::*;
#(
  parameter logic [31:0] LONG_WIN = mode_ctrl_pkg::LONG_WIN_CYC
)
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [mode_ctrl_pkg::FRAME_W-1:0] i_frame,
  input wire logic i_frame_valid,
  input wire logic i_wd_trigger,
  input wire logic i_supply_low,
  input wire logic i_overvolt,
  input wire logic i_vs_low,
  input wire logic i_int_pin,
  input wire logic i_por_pending,
  input wire logic [mode_ctrl_pkg::WAKE_N-1:0] i_wake_event,
  input wire logic i_overvolt_reset_enable,
  input wire logic i_wake_measure_select,
  output logic o_irq_output,
  output logic o_reset_output,
  output logic o_fail_output,
  output logic o_overvolt_flag,
  output logic o_undervolt_flag,
  output logic o_spi_error_flag,
  output logic o_wd_fail_flag,
  output logic o_config_pin_level,
  output logic o_second_supply,
  output logic o_third_supply,
  output logic o_can_on,
  output logic o_lin_on,
  output logic [2*mode_ctrl_pkg::HS_N-1:0] o_high_side_switch,
  output logic [1:0] o_mode_bits,
  output logic [mode_ctrl_pkg::WAKE_N-1:0] o_wake_status,
  output logic [5:0] o_mode
);
  mode_t state_r;
  mode_t state_nxt;
  logic int_lvl;
  logic ov_lvl;
  logic [2:0] cmd;
  logic is_write;
  logic stop_ok;
  logic [31:0] wd_cnt_r;
  logic [15:0] rd_cnt_r;
  logic wd_seen_r;
  logic cfg_sample_r;
  logic ov_prev_r;
  logic fail_latch_r;
  logic fail_test_r;
  logic stop_prev_r;

  pin_sync3 u_int_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_int_pin),
    .o_level(int_lvl)
  );
  pin_sync3 u_ov_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_overvolt),
    .o_level(ov_lvl)
  );
  frame_decode u_dec (
    .i_frame(i_frame),
    .o_cmd(cmd),
    .o_write(is_write),
    .o_stop_allowed(stop_ok)
  );

  wire ov_event = ov_lvl && !ov_prev_r;
  wire ov_act = ov_event && i_overvolt_reset_enable; // [R1]
  wire wd_expire = (state_r == ST_INIT) && !wd_seen_r && (wd_cnt_r >= LONG_WIN - 1); // [R7]
  wire in_run = (state_r == ST_NORMAL) || (state_r == ST_STOP);
  wire spi_live = i_frame_valid && (state_r != ST_RESTART);
  wire mode_wr = spi_live && is_write && (cmd == CMD_MODE);
  wire [1:0] req_mode = i_frame[1:0];
  wire stop_block = spi_live && (state_r == ST_STOP) && is_write && !stop_ok; // [R18]
  wire stop_sleep = mode_wr && (state_r == ST_STOP) && (req_mode == MB_SLEEP); // [R21]
  wire cfg_wr = spi_live && is_write && (state_r == ST_NORMAL); // [R19]
  wire soft_rst = mode_wr && (req_mode == MB_RESET) && in_run;
  // Measurement mode removes the first two wake inputs as sources
  wire [WAKE_N-1:0] wake_mask = i_wake_measure_select ? 3'h4 : 3'h7; // [R22]
  wire [WAKE_N-1:0] wake_acc = i_wake_event & wake_mask;
  wire wake_any = in_run && (wake_acc != 3'h0); // [R8] [R12]
  wire stop_entry = (state_r == ST_STOP) && !stop_prev_r;
  // Failure count per configuration is not modelled: every expiry drives the fail output
  wire fail_set = ov_act || wd_expire; // [R16]
  wire rd_done = (state_r == ST_RESTART) && (rd_cnt_r >= RD_CYC - 16'h1) && !i_supply_low;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT:
      begin
        if (wd_expire)
          state_nxt = ST_RESTART; // [R7]
        else if (i_frame_valid)
          state_nxt = ST_NORMAL; // [R5]
      end
      ST_NORMAL, ST_STOP:
      begin
        if (stop_sleep)
          state_nxt = ST_RESTART; // [R21]
        else if (mode_wr && req_mode == MB_STOP)
          state_nxt = ST_STOP;
        else if (mode_wr && req_mode == MB_NORMAL)
          state_nxt = ST_NORMAL;
        else if (mode_wr && req_mode == MB_SLEEP)
          state_nxt = ST_SLEEP;
      end
      ST_RESTART:
      begin
        if (rd_done)
          state_nxt = ST_NORMAL;
      end
      ST_SLEEP, ST_FAILSAFE:
        state_nxt = state_r;
      default:
        state_nxt = ST_INIT;
    endcase
    if (soft_rst)
      state_nxt = ST_INIT;
    // Overvoltage with reset enabled takes priority over any host request
    if (ov_act && state_r != ST_FAILSAFE)
      state_nxt = cfg_sample_r ? ST_RESTART : ST_FAILSAFE; // [R2] [R3]
    if (i_supply_low && in_run)
      state_nxt = ST_RESTART;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_r <= ST_INIT;
      stop_prev_r <= 1'b0;
      ov_prev_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      stop_prev_r <= (state_r == ST_STOP);
      ov_prev_r <= ov_lvl;
    end
  end

  // Long open window counts while in init, from reset release or soft-reset entry
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || state_r != ST_INIT)
    begin
      wd_cnt_r <= 32'h0;
      wd_seen_r <= 1'b0;
    end
    else
    begin
      wd_cnt_r <= wd_cnt_r + 32'h1;
      if (i_wd_trigger)
        wd_seen_r <= 1'b1; // [R6] [R9]
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || state_r != ST_RESTART)
      rd_cnt_r <= 16'h0;
    else if (rd_cnt_r != RD_CYC)
      rd_cnt_r <= rd_cnt_r + 16'h1;
  end

  // Reset output low while supply is low and through the restart delay
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_reset_output <= 1'b0;
    else
      o_reset_output <= !i_supply_low && (state_nxt != ST_RESTART); // [R11]
  end

  // Configuration is caught only at the reset-output rising edge
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cfg_sample_r <= 1'b0;
      o_config_pin_level <= 1'b0;
    end
    else if (!o_reset_output && !i_supply_low && (state_nxt != ST_RESTART)
      && (i_por_pending || state_r == ST_INIT))
    begin
      cfg_sample_r <= int_lvl; // [R23] [R4]
      o_config_pin_level <= int_lvl;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_overvolt_flag <= 1'b0;
      o_undervolt_flag <= 1'b0;
      o_spi_error_flag <= 1'b0;
      o_wd_fail_flag <= 1'b0;
      fail_latch_r <= 1'b0;
    end
    else
    begin
      if (ov_event)
        o_overvolt_flag <= 1'b1; // [R1] [R2] [R3]
      else if (spi_live && cmd == CMD_STATUS && is_write)
        o_overvolt_flag <= 1'b0;
      // Undervolt only counts once the run modes are reached
      if (i_supply_low && in_run && !i_vs_low)
        o_undervolt_flag <= 1'b1; // [R10]
      else if (spi_live && cmd == CMD_STATUS && is_write)
        o_undervolt_flag <= 1'b0;
      if (stop_block || stop_sleep)
        o_spi_error_flag <= 1'b1; // [R18] [R21]
      else if (spi_live && cmd == CMD_STATUS && is_write)
        o_spi_error_flag <= 1'b0;
      if (wd_expire)
        o_wd_fail_flag <= 1'b1; // [R7]
      else if (spi_live && cmd == CMD_STATUS && is_write)
        o_wd_fail_flag <= 1'b0;
      if (fail_set)
        fail_latch_r <= 1'b1; // [R16]
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      fail_test_r <= 1'b0;
    else if (cfg_wr && cmd == CMD_MISC)
      fail_test_r <= i_frame[0]; // [R17]
    else if (state_r != ST_NORMAL && state_r != ST_STOP)
      fail_test_r <= 1'b0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_fail_output <= 1'b0;
    else
      o_fail_output <= fail_latch_r || fail_set || fail_test_r; // [R16] [R17]
  end

  // Peripheral enables; restart clears second supply, high-side, CAN and LIN, init clears everything
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_second_supply <= 1'b0;
      o_third_supply <= 1'b0;
      o_can_on <= 1'b0;
      o_lin_on <= 1'b0;
      o_high_side_switch <= '0;
    end
    else if (state_r == ST_INIT)
    begin
      o_third_supply <= 1'b0; // [R14]
      o_can_on <= 1'b0;
      o_lin_on <= 1'b0;
      o_second_supply <= 1'b0; // [R13]
      o_high_side_switch <= '0;
    end
    else if (state_r == ST_RESTART)
    begin
      o_second_supply <= 1'b0;
      o_high_side_switch <= '0; // [R15]
      o_can_on <= 1'b0; // [R14]
      o_lin_on <= 1'b0;
    end
    else if (cfg_wr && cmd == CMD_SUPPLY)
    begin
      o_second_supply <= i_frame[0]; // [R13]
      o_third_supply <= i_frame[1];
      o_can_on <= i_frame[2];
      o_lin_on <= i_frame[3];
    end
    else if (cfg_wr && cmd == CMD_HS)
      o_high_side_switch <= i_frame[2*HS_N-1:0]; // [R13]
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_wake_status <= '0;
    else if (wake_any)
      o_wake_status <= o_wake_status | wake_acc; // [R12]
    else if (spi_live && cmd == CMD_STATUS && is_write)
      o_wake_status <= '0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_irq_output <= 1'b0;
      o_mode_bits <= MB_NORMAL;
      o_mode <= ST_INIT;
    end
    else
    begin
      o_irq_output <= wake_any || (stop_entry && o_wake_status != 3'h0); // [R12] [R20]
      o_mode <= state_nxt;
      if (state_r == ST_RESTART)
        o_mode_bits <= MB_NORMAL; // [R24]
      else if (mode_wr && state_nxt != ST_RESTART)
        o_mode_bits <= req_mode; // [R24] [R25]
    end
  end

  ov_no_reset_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (ov_event && !i_overvolt_reset_enable && in_run && !i_supply_low && !mode_wr)
      |=> (state_r == $past(state_r)) && o_overvolt_flag) else $error("ov changed mode"); // [R1]
  ov_restart_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (ov_act && cfg_sample_r && state_r != ST_FAILSAFE) |=> state_r == ST_RESTART ##1 o_fail_output)
    else $error("ov restart missed"); // [R2]
  ov_failsafe_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (ov_act && !cfg_sample_r) |=> state_r == ST_FAILSAFE) else $error("ov failsafe missed"); // [R3]
  init_frame_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == ST_INIT && i_frame_valid && !wd_expire && !ov_act && !soft_rst)
      |=> state_r == ST_NORMAL) else $error("init frame ignored"); // [R5]
  wd_expire_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wd_expire && !ov_act |=> state_r == ST_RESTART && o_wd_fail_flag) else $error("wd expiry"); // [R7]
  init_wake_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == ST_INIT) |=> !o_irq_output) else $error("wake in init"); // [R8]
  stop_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    stop_block |=> o_spi_error_flag && $stable(o_high_side_switch)) else $error("stop write"); // [R18]
  stop_sleep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    stop_sleep && !ov_act |=> state_r == ST_RESTART ##1 o_mode_bits == MB_NORMAL)
    else $error("stop sleep"); // [R21]
  rst_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_supply_low |=> !o_reset_output) else $error("reset released"); // [R11]
  hs_restart_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == ST_RESTART) |=> o_high_side_switch == '0) else $error("hs on"); // [R15]
endmodule
`default_nettype wire

/* File: src/mode_ctrl_pkg.sv */
// Constants and types shared by the operating-mode controller.
// Summary of operation
// R1 - Overvoltage without reset enable: flag only
// R2 - Overvoltage, pull-up config: fail output, restart
// R3 - Overvoltage, no pull-up: fail output, fail-safe
// R4 - Stored configuration kept until power-down
// R5 - Any frame in init goes normal
// R6 - Host triggers watchdog in long window
// R7 - Long window expiry: watchdog failure, restart
// R8 - Wake events in init are discarded
// R9 - Host's first command triggers watchdog
// R10 - No undervolt or fail at power-up
// R11 - Reset output low while supply low
// R12 - Wake in normal/stop raises interrupt only
// R13 - Second supply, high-side default off, switchable
// R14 - Init entry: third supply, CAN, LIN off
// R15 - Normal from restart: high-side outputs off
// R16 - Fail output off, may persist after restart
// R17 - Host test bit drives fail output
// R18 - Stop mode blocks writes, sets SPI error
// R19 - Stop mode keeps normal-mode settings
// R20 - Stop entry with pending wake flags interrupts
// R21 - Stop to sleep refused, restart
// R22 - Measurement select masks first two wakes
// R23 - Interrupt pin level caught at reset release
// R24 - Host writes mode bits; cleared through restart
// R25 - Frames are sixteen bits
package mode_ctrl_pkg;
  localparam int FRAME_W = 16;
  localparam int HS_N = 4;
  localparam int WAKE_N = 3;
  localparam int CLK_HZ = 40_000_000;
  localparam int LONG_WIN_MS = 200;
  localparam int RESET_DELAY_US = 10;
  localparam int RD_CYC_I = (RESET_DELAY_US * (CLK_HZ / 1_000_000));
  localparam logic [15:0] RD_CYC = 16'(RD_CYC_I);
  localparam logic [31:0] LONG_WIN_CYC = 32'(LONG_WIN_MS * (CLK_HZ / 1000));
  // Command field positions inside a frame
  localparam int CMD_LSB = 13;
  localparam logic [2:0] CMD_MODE = 3'h1;
  localparam logic [2:0] CMD_SOFT_RST = 3'h2;
  localparam logic [2:0] CMD_WD_REFRESH = 3'h3;
  localparam logic [2:0] CMD_STATUS = 3'h4;
  localparam logic [2:0] CMD_SUPPLY = 3'h5;
  localparam logic [2:0] CMD_HS = 3'h6;
  localparam logic [2:0] CMD_MISC = 3'h7;
  localparam logic [1:0] MB_NORMAL = 2'h0;
  localparam logic [1:0] MB_SLEEP = 2'h1;
  localparam logic [1:0] MB_STOP = 2'h2;
  localparam logic [1:0] MB_RESET = 2'h3;
  localparam logic [1:0] HS_OFF = 2'h0;
  localparam logic [1:0] HS_ON = 2'h1;
  localparam logic [1:0] HS_PWM = 2'h2;
  typedef enum logic [5:0] {
    ST_INIT = 6'h01,
    ST_NORMAL = 6'h02,
    ST_STOP = 6'h04,
    ST_SLEEP = 6'h08,
    ST_RESTART = 6'h10,
    ST_FAILSAFE = 6'h20
  } mode_t;
endpackage

/* File: src/pin_sync3.sv */
// Three-stage input synchroniser that changes when the last two stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        o_level <= s3_r;
    end
  end
endmodule
`default_nettype wire

/* File: src/frame_decode.sv */
// Splits a received 16-bit frame into command class and mode-access flags.
`timescale 1ns/1ps
`default_nettype none
module frame_decode
  import mode_ctrl_pkg::*;
(
  input wire logic [mode_ctrl_pkg::FRAME_W-1:0] i_frame,
  output logic [2:0] o_cmd,
  output logic o_write,
  output logic o_stop_allowed
);
  assign o_cmd = i_frame[CMD_LSB +: 3]; // [R25]
  assign o_write = i_frame[12];
  // Mode change, soft reset, watchdog refresh and status access pass in stop
  assign o_stop_allowed = !o_write || (o_cmd == CMD_MODE) || (o_cmd == CMD_SOFT_RST)
    || (o_cmd == CMD_WD_REFRESH) || (o_cmd == CMD_STATUS); // [R18]
endmodule
`default_nettype wire

/* File: tb/host_model.sv */
// Host microcontroller model: sends frames and keeps the watchdog refreshed.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import mode_ctrl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_keep_alive,
  output logic [mode_ctrl_pkg::FRAME_W-1:0] o_frame,
  output logic o_frame_valid,
  output logic o_wd_trigger
);
  logic first_r = 1'b1;
  logic [5:0] cnt = 6'h00;
  initial
  begin
    o_frame = 16'h0000;
    o_frame_valid = 1'b0;
    o_wd_trigger = 1'b0;
  end
  // One frame per valid pulse; the line is inverted once released
  task automatic send(input logic [FRAME_W-1:0] f);
    @(negedge i_core_clk);
    o_frame = f;
    o_frame_valid = 1'b1;
    o_wd_trigger = first_r;
    first_r = 1'b0;
    @(negedge i_core_clk);
    o_frame = ~f;
    o_frame_valid = 1'b0;
  endtask
  // Refresh every 64 cycles, well inside the shortened long window
  always @(negedge i_core_clk)
  begin
    cnt = cnt + 6'h01;
    if (!o_frame_valid)
      o_wd_trigger = i_keep_alive && (cnt == 6'h00);
  end
endmodule
`default_nettype wire

/* File: tb/test_system_mode_controller.sv */
// Self-checking bench for the operating-mode controller.
`timescale 1ns/1ps
`default_nettype none
module test_system_mode_controller;
  import mode_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sup_low = 1'b1;
  logic ovv = 1'b0;
  logic vs_low = 1'b1;
  logic int_pin = 1'b1;
  logic por = 1'b1;
  logic [2:0] wk = 3'h0;
  logic oven = 1'b0;
  logic meas = 1'b0;
  logic keep = 1'b1;
  logic [15:0] frame;
  logic fv, wdt, irq, ro, fo, ovf, uvf, spie, wdf, cfg, s2, s3, can, lin;
  logic [7:0] hs, hs_e;
  logic [1:0] mb, fld;
  logic [2:0] wks;
  logic [5:0] o_mode, prev_mode = 6'h01;
  logic [5:0] exp_q[$];
  logic [31:0] r = 32'h54df4b23;
  int fail_count = 0;
  int check_count = 0;
  int irq_cnt = 0;
  int base, cycles = 0;

  host_model host_model_inst (.i_core_clk(clk), .i_keep_alive(keep), .o_frame(frame),
    .o_frame_valid(fv), .o_wd_trigger(wdt));
  system_mode_controller #(.LONG_WIN(32'h64)) system_mode_controller_inst (
    .i_core_clk(clk), .i_rst(rst), .i_frame(frame), .i_frame_valid(fv), .i_wd_trigger(wdt),
    .i_supply_low(sup_low), .i_overvolt(ovv), .i_vs_low(vs_low), .i_int_pin(int_pin),
    .i_por_pending(por), .i_wake_event(wk), .i_overvolt_reset_enable(oven),
    .i_wake_measure_select(meas), .o_irq_output(irq), .o_reset_output(ro),
    .o_fail_output(fo), .o_overvolt_flag(ovf), .o_undervolt_flag(uvf),
    .o_spi_error_flag(spie), .o_wd_fail_flag(wdf), .o_config_pin_level(cfg),
    .o_second_supply(s2), .o_third_supply(s3), .o_can_on(can), .o_lin_on(lin),
    .o_high_side_switch(hs), .o_mode_bits(mb), .o_wake_status(wks), .o_mode(o_mode));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wake(input logic [2:0] b);
    @(negedge clk);
    wk = b;
    @(negedge clk);
    wk = 3'h0;
    cyc(4);
  endtask

  task automatic wait_mode(input logic [5:0] m);
    int n;
    n = 0;
    while (o_mode !== m && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    check(8'(o_mode), 8'(m));
  endtask

  // Mode changes are the results taken off the queue
  always @(negedge clk)
  begin
    if (!rst && o_mode !== prev_mode)
      check(8'(o_mode), (exp_q.size() > 0) ? 8'(exp_q.pop_front()) : 8'hff);
    prev_mode <= o_mode;
    if (irq === 1'b1)
      irq_cnt++;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  initial
  begin
    // Levels that must not matter before the first frame start random
    r = lfsr(r);
    {oven, por, vs_low} = r[2:0];
    cyc(20);
    check(8'({ro, uvf, fo}), 8'h00);
    rst = 1'b0;
    cyc(50);
    check(8'({ro, uvf, fo}), 8'h00);
    sup_low = 1'b0;
    vs_low = 1'b0;
    cyc(450);
    check(8'({ro, cfg}), 8'h03);
    r = lfsr(r);
    wake(r[2:0] | 3'h1);
    check(8'({wks, 5'(irq_cnt)}), 8'h00);
    exp_q.push_back(ST_NORMAL);
    host_model_inst.send(16'h0000);
    cyc(4);
    check(8'({s2, s3, can, lin, fo}), 8'h00);
    check(hs, 8'h00);
    host_model_inst.send(16'hb00f);
    cyc(3);
    check(8'({s2, s3, can, lin}), 8'h0f);
    for (int k = 0; k < 3; k++)
    begin
      r = lfsr(r);
      for (int i = 0; i < 4; i++)
      begin
        fld = r[2*i+:2];
        hs_e[2*i+:2] = (fld == 2'h3) ? HS_PWM : fld;
      end
      host_model_inst.send({8'hd0, hs_e});
      cyc(3);
      check(hs, hs_e);
    end
    host_model_inst.send(16'hf001);
    cyc(3);
    check(8'(fo), 8'h01);
    host_model_inst.send(16'hf000);
    cyc(3);
    check(8'(fo), 8'h00);
    $display("test normal done");
    meas = 1'b1;
    wake(3'h1);
    check(8'(wks), 8'h00);
    base = irq_cnt;
    // The third wake input is a source whatever the measurement select
    meas = r[3];
    wake(3'h4);
    meas = 1'b0;
    check(8'({wks, 5'(irq_cnt - base)}), {3'h4, 5'h01});
    base = irq_cnt;
    exp_q.push_back(ST_STOP);
    host_model_inst.send(16'h3002);
    cyc(4);
    check(8'(irq_cnt - base), 8'h01);
    host_model_inst.send(16'hb000);
    cyc(3);
    check(8'({spie, s2, s3, can, lin}), 8'h1f);
    base = irq_cnt;
    wake(3'h4);
    check(8'(irq_cnt - base), 8'h01);
    exp_q.push_back(ST_RESTART);
    exp_q.push_back(ST_NORMAL);
    host_model_inst.send(16'h3001);
    wait_mode(ST_RESTART);
    cyc(2);
    check(8'({spie, ro}), 8'h02);
    wait_mode(ST_NORMAL);
    cyc(3);
    check(hs, 8'h00);
    check(8'({s3, can, lin, mb, ro}), 8'h21);
    $display("test stop done");
    exp_q.push_back(ST_RESTART);
    exp_q.push_back(ST_NORMAL);
    sup_low = 1'b1;
    wait_mode(ST_RESTART);
    check(8'({uvf, ro}), 8'h02);
    sup_low = 1'b0;
    wait_mode(ST_NORMAL);
    exp_q.push_back(ST_INIT);
    exp_q.push_back(ST_NORMAL);
    host_model_inst.send(16'h3003);
    wait_mode(ST_INIT);
    host_model_inst.send(16'h0000);
    wait_mode(ST_NORMAL);
    cyc(3);
    check(8'({s3, can, lin}), 8'h00);
    oven = 1'b0;
    $display("test restart done");
    host_model_inst.send(16'h9000);
    ovv = 1'b1;
    cyc(10);
    ovv = 1'b0;
    cyc(6);
    check(8'({ovf, fo}), 8'h02);
    check(8'(o_mode), 8'(ST_NORMAL));
    oven = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      host_model_inst.send(16'h9000);
      exp_q.push_back(ST_RESTART);
      exp_q.push_back(ST_NORMAL);
      ovv = 1'b1;
      wait_mode(ST_RESTART);
      ovv = 1'b0;
      wait_mode(ST_NORMAL);
      cyc(3);
      check(8'({ovf, fo, cfg}), 8'h07);
      int_pin = 1'b0;
      por = 1'b0;
    end
    $display("test overvoltage done");
    rst = 1'b1;
    keep = 1'b0;
    oven = 1'b0;
    por = 1'b1;
    cyc(20);
    // Expiry comes long before the wait ends, so the notes go in first
    exp_q.push_back(ST_RESTART);
    exp_q.push_back(ST_NORMAL);
    rst = 1'b0;
    cyc(450);
    check(8'(cfg), 8'h00);
    wait_mode(ST_RESTART);
    keep = 1'b1;
    check(8'(wdf), 8'h01);
    wait_mode(ST_NORMAL);
    oven = 1'b1;
    exp_q.push_back(ST_FAILSAFE);
    ovv = 1'b1;
    wait_mode(ST_FAILSAFE);
    cyc(3);
    check(8'({ovf, fo}), 8'h03);
    check(8'(exp_q.size()), 8'h00);
    $display("test watchdog done");
    summarize();
  end
endmodule
`default_nettype wire
